// *** verilog/hall_comm_pkg.sv ***
// package: constants and types for hall trapezoidal commutation
package hall_comm_pkg;
  localparam int SENSOR_W    = 3;
  localparam int COUNT_W     = 32;
  localparam int POLE_W      = 8;
  localparam int SPEED_W     = 24;
  localparam int STEPS_PER_E = 6;    // patterns per electrical cycle
  localparam int DEG_PER_STEP = 60;  // electrical degrees per pattern
  // speed measuring window, in microseconds, and its cycle count
  localparam int WINDOW_US   = 100000;
  localparam int CLK_MHZ     = 50;
  localparam int WINDOW_CYC  = WINDOW_US * CLK_MHZ;
  // spacing select codes
  localparam logic SPACING_120 = 1'b0;
  localparam logic SPACING_60  = 1'b1;
  // drive code per phase: off, high side, low side
  typedef enum logic [1:0] {PH_OFF, PH_HIGH, PH_LOW} phase_drive_t;
endpackage

// *** verilog/hall_trapezoidal_commutation.sv ***
// hall sensor driven trapezoidal commutation with turn and speed counting
// How it works
// - two of three phases carry current, pair rotates, direction alternates
// - six distinct patterns, one step per 60 electrical degrees
// - pattern chosen directly from present hall sensor levels
// - spacing select picks 120 or 60 degree sensor decoding
// - hall counter steps on every sensor change to a valid state, six per cycle
// - turns and speed are electrical cycles divided by pole pairs
// - negative pole pair count inverts speed and count direction
// - commutation ignores pole pair setting entirely
// - sensor state presented as three bits, values 0 to 7
// - in 120 spacing states 1 to 6 valid, 0 and 7 invalid
// - in 60 spacing states 2 and 5 invalid, others valid
// - order map 0 to 5 permutes the three inputs before decode
module hall_trapezoidal_commutation
#(
  parameter int WINDOW_CYCLES = hall_comm_pkg::WINDOW_CYC
)
(
  input  wire logic                                    i_clk,
  input  wire logic                                    i_nrst,
  input  wire logic                                    i_rotor_sensor_a,
  input  wire logic                                    i_rotor_sensor_b,
  input  wire logic                                    i_rotor_sensor_c,
  input  wire logic                                    i_sensor_spacing_select,
  input  wire logic [2:0]                              i_sensor_order_map,
  input  wire logic signed [hall_comm_pkg::POLE_W-1:0] i_pole_pair_count,
  output logic      [1:0]                              o_phase_u,
  output logic      [1:0]                              o_phase_v,
  output logic      [1:0]                              o_phase_w,
  output logic                                         o_state_valid,
  output logic      [hall_comm_pkg::SENSOR_W-1:0]      o_sensor_state_query,
  output logic signed [hall_comm_pkg::COUNT_W-1:0]     o_hall_count,
  output logic signed [hall_comm_pkg::COUNT_W-1:0]     o_turn_count,
  output logic signed [hall_comm_pkg::SPEED_W-1:0]     o_speed
);
  import hall_comm_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  logic [SENSOR_W-1:0] sync1;
  logic [SENSOR_W-1:0] sync2;
  logic [SENSOR_W-1:0] hall_prev;
  logic                prev_ok;
  logic [1:0]          warm;     // high once sync2 holds real pin data

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      warm  <= 2'h0;
    end
    else
    begin
      sync1 <= {i_rotor_sensor_c, i_rotor_sensor_b, i_rotor_sensor_a};
      sync2 <= sync1;
      warm  <= {warm[0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  // permute sensors; unused map codes fall back to identity
  function automatic logic [2:0] permute(input logic [2:0] s,
                                         input logic [2:0] m);
    logic [2:0] r;
    r = s;
    unique case (m)
      3'h1:    r = {s[1], s[2], s[0]};
      3'h2:    r = {s[2], s[0], s[1]};
      3'h3:    r = {s[0], s[2], s[1]};
      3'h4:    r = {s[1], s[0], s[2]};
      3'h5:    r = {s[0], s[1], s[2]};
      default: r = s;
    endcase
    return r;
  endfunction

  // sector 0..5 from a state; 7 marks invalid
  function automatic logic [2:0] sector_of(input logic [2:0] s,
                                           input logic sp);
    logic [2:0] r;
    r = 3'h7;
    if (sp == SPACING_120)
      case (s)
        3'h1: r = 3'h0;
        3'h3: r = 3'h1;
        3'h2: r = 3'h2;
        3'h6: r = 3'h3;
        3'h4: r = 3'h4;
        3'h5: r = 3'h5;
        default: r = 3'h7;
      endcase
    else
      // 60 degree spacing: middle sensor is inverted relative to 120
      case (s)
        3'h0: r = 3'h0;
        3'h1: r = 3'h1;
        3'h3: r = 3'h2;
        3'h7: r = 3'h3;
        3'h6: r = 3'h4;
        3'h4: r = 3'h5;
        default: r = 3'h7;
      endcase
    return r;
  endfunction

  logic [2:0] mapped;
  logic [2:0] sector;
  logic [2:0] prev_sector;
  logic       valid;

  assign mapped = permute(sync2, i_sensor_order_map);
  assign sector = sector_of(mapped, i_sensor_spacing_select);
  assign valid  = (sector != 3'h7);
  assign prev_sector = sector_of(permute(hall_prev, i_sensor_order_map),
                                 i_sensor_spacing_select);

  // ---------------------------------------------------------------
  // commutation table
  // ---------------------------------------------------------------
  phase_drive_t next_u;
  phase_drive_t next_v;
  phase_drive_t next_w;

  // one pair per sector, pole pairs not used here
  always_comb
  begin
    next_u = PH_OFF;
    next_v = PH_OFF;
    next_w = PH_OFF;
    unique case (sector)
      3'h0: begin next_u = PH_HIGH; next_v = PH_LOW;  end
      3'h1: begin next_u = PH_HIGH; next_w = PH_LOW;  end
      3'h2: begin next_v = PH_HIGH; next_w = PH_LOW;  end
      3'h3: begin next_v = PH_HIGH; next_u = PH_LOW;  end
      3'h4: begin next_w = PH_HIGH; next_u = PH_LOW;  end
      3'h5: begin next_w = PH_HIGH; next_v = PH_LOW;  end
      default: ; // invalid state, all phases off
    endcase
  end

  // registered phase drive and state report
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_phase_u            <= PH_OFF;
      o_phase_v            <= PH_OFF;
      o_phase_w            <= PH_OFF;
      o_state_valid        <= 1'b0;
      o_sensor_state_query <= 3'h0;
    end
    else
    begin
      o_phase_u            <= next_u;
      o_phase_v            <= next_v;
      o_phase_w            <= next_w;
      o_state_valid        <= valid;
      o_sensor_state_query <= sync2;
    end
  end

  // ---------------------------------------------------------------
  // hall, turn and speed counting
  // ---------------------------------------------------------------
  logic       change;
  logic       fwd;
  logic [2:0] step_in_cycle;
  logic [2:0] sector_diff;
  logic signed [COUNT_W-1:0] elec_cycles;
  logic signed [COUNT_W-1:0] win_cycles;
  logic [31:0] win_cnt;
  logic        neg_pole;
  logic [POLE_W-1:0] pole_mag;

  assign change   = prev_ok && (sync2 != hall_prev) && valid;
  assign sector_diff = (sector + 3'h6 - prev_sector) % 3'h6;
  assign fwd      = (sector_diff == 3'h1) || (prev_sector == 3'h7);
  assign neg_pole = i_pole_pair_count[POLE_W-1];
  assign pole_mag = neg_pole ? POLE_W'(-i_pole_pair_count)
                             : i_pole_pair_count;

  // count every change to a valid state, sign follows pole setting
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      hall_prev     <= 3'h0;
      prev_ok       <= 1'b0;
      o_hall_count  <= '0;
      step_in_cycle <= 3'h0;
      elec_cycles   <= '0;
    end
    else
    begin
      hall_prev <= sync2;
      // reset zeros in the sync stages must not look like a sensor edge
      prev_ok   <= warm[1];
      if (change)
      begin
        if (fwd ^ neg_pole)
        begin
          o_hall_count <= o_hall_count + COUNT_W'(1);
          if (step_in_cycle == 3'(STEPS_PER_E - 1))
          begin
            step_in_cycle <= 3'h0;
            elec_cycles   <= elec_cycles + COUNT_W'(1);
          end
          else
            step_in_cycle <= step_in_cycle + 3'h1;
        end
        else
        begin
          o_hall_count <= o_hall_count - COUNT_W'(1);
          if (step_in_cycle == 3'h0)
          begin
            step_in_cycle <= 3'(STEPS_PER_E - 1);
            elec_cycles   <= elec_cycles - COUNT_W'(1);
          end
          else
            step_in_cycle <= step_in_cycle - 3'h1;
        end
      end
    end
  end

  // turns and per-window speed are electrical cycles over pole pairs
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_turn_count <= '0;
      o_speed      <= '0;
      win_cnt      <= 32'h0;
      win_cycles   <= '0;
    end
    else
    begin
      o_turn_count <= (pole_mag == '0) ? elec_cycles
                      : elec_cycles / $signed({1'b0, pole_mag});
      if (win_cnt >= 32'(WINDOW_CYCLES - 1))
      begin
        win_cnt    <= 32'h0;
        win_cycles <= elec_cycles;
        o_speed    <= (pole_mag == '0) ? SPEED_W'(elec_cycles - win_cycles)
                      : SPEED_W'((elec_cycles - win_cycles)
                                 / $signed({1'b0, pole_mag}));
      end
      else
        win_cnt <= win_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  two_phases_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_state_valid |-> ((o_phase_u != PH_OFF) + (o_phase_v != PH_OFF)
                       + (o_phase_w != PH_OFF)) == 2)
    else $error("not exactly two phases driven");
  invalid_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_state_valid |-> o_phase_u == PH_OFF && o_phase_v == PH_OFF
                       && o_phase_w == PH_OFF)
    else $error("phase driven on invalid state");
  inv120_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sensor_spacing_select == SPACING_120 && (mapped == 3'h0
     || mapped == 3'h7)) |=> !o_state_valid)
    else $error("120 spacing invalid state accepted");
  inv60_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_sensor_spacing_select == SPACING_60 && (mapped == 3'h2
     || mapped == 3'h5)) |=> !o_state_valid)
    else $error("60 spacing invalid state accepted");
  query_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ##1 o_sensor_state_query == $past(sync2))
    else $error("state query mismatch");
  count_step_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    change |=> (o_hall_count - $past(o_hall_count) == 1
             || $past(o_hall_count) - o_hall_count == 1))
    else $error("hall count did not step by one");
  count_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !change |=> $stable(o_hall_count))
    else $error("hall count moved without change");
  // a counted step in the forward sense of the sensor sequence
  sequence seq_fwd_step;
    change && fwd;
  endsequence
  neg_dir_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    seq_fwd_step ##0 neg_pole |=> o_hall_count < $past(o_hall_count))
    else $error("negative pole count did not reverse");
endmodule

// *** verif/hall_sensor_model.sv ***
// hall sensor model: rotor sector to three sensor levels, raw override
module hall_sensor_model
(
  input  wire logic       i_spacing,
  input  wire logic [2:0] i_sector,
  input  wire logic       i_raw_en,
  input  wire logic [2:0] i_raw,
  output logic            o_a,
  output logic            o_b,
  output logic            o_c
);
  logic [2:0] st;

  // sector walk yields only valid states
  always_comb
  begin
    case (i_sector)
      3'h0: st = i_spacing ? 3'h0 : 3'h1;
      3'h1: st = i_spacing ? 3'h1 : 3'h3;
      3'h2: st = i_spacing ? 3'h3 : 3'h2;
      3'h3: st = i_spacing ? 3'h7 : 3'h6;
      3'h4: st = i_spacing ? 3'h6 : 3'h4;
      default: st = i_spacing ? 3'h4 : 3'h5;
    endcase
    {o_c, o_b, o_a} = i_raw_en ? i_raw : st;
  end
endmodule

// *** verif/tb_hall_trapezoidal_commutation.sv ***
// self-checking bench for the hall trapezoidal commutation block
module tb_hall_trapezoidal_commutation;
  timeunit 1ns;
  timeprecision 1ps;
  import hall_comm_pkg::*;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end

  logic                       clk, nrst, spacing, raw_en;
  logic [2:0]                 map, sector, raw;
  logic signed [POLE_W-1:0]   poles;
  logic                       sa, sb, sc, valid;
  logic [1:0]                 pu, pv, pw;
  logic [SENSOR_W-1:0]        query;
  logic signed [COUNT_W-1:0]  hall, turns;
  logic signed [SPEED_W-1:0]  speed;
  logic [5:0]                 pat [6];
  int                         n_errors, checks;

  hall_sensor_model u_hall_sensor_model (.i_spacing(spacing),
    .i_sector(sector), .i_raw_en(raw_en), .i_raw(raw),
    .o_a(sa), .o_b(sb), .o_c(sc));

  // short speed window keeps the run brief
  hall_trapezoidal_commutation #(.WINDOW_CYCLES(100))
    u_hall_trapezoidal_commutation (.i_clk(clk), .i_nrst(nrst),
    .i_rotor_sensor_a(sa), .i_rotor_sensor_b(sb), .i_rotor_sensor_c(sc),
    .i_sensor_spacing_select(spacing), .i_sensor_order_map(map),
    .i_pole_pair_count(poles), .o_phase_u(pu), .o_phase_v(pv),
    .o_phase_w(pw), .o_state_valid(valid), .o_sensor_state_query(query),
    .o_hall_count(hall), .o_turn_count(turns), .o_speed(speed));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // 3-cycle pin-to-output latency, two spare edges
  task put(input logic en, input logic [2:0] s);
    @(posedge clk);
    raw_en <= en;
    if (en) raw <= s;
    else sector <= s;
    repeat (5) @(posedge clk);
  endtask

  // config is applied while reset is held so the first sector is not a step
  task do_reset(input logic sp, input logic signed [7:0] p);
    @(posedge clk);
    nrst <= 1'b0;
    spacing <= sp;
    poles <= p;
    map <= 3'h0;
    raw_en <= 1'b0;
    sector <= 3'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // one electrical cycle, then the two invalid codes of the spacing
  task t_sweep(input logic sp, input logic [2:0] bad0, input logic [2:0] bad1);
    logic signed [COUNT_W-1:0] base;
    logic [5:0] p;
    int hi, lo, df;
    do_reset(sp, 8'sh01);
    base = hall;
    for (int i = 1; i <= 6; i++)
    begin
      put(1'b0, 3'(i % 6));
      p = {pu, pv, pw};
      hi = (pu == PH_HIGH) + (pv == PH_HIGH) + (pw == PH_HIGH);
      lo = (pu == PH_LOW) + (pv == PH_LOW) + (pw == PH_LOW);
      df = (p[5:4] != pat[(i+5)%6][5:4]) + (p[3:2] != pat[(i+5)%6][3:2])
        + (p[1:0] != pat[(i+5)%6][1:0]);
      `CHK("valid", 1'b1, valid)
      `CHK("query", {sc, sb, sa}, query)
      `CHK("highs lows", 2, hi + lo * 4 - 3)
      `CHK("hall count", base + i, hall)
      if (sp == SPACING_120 && i < 6) pat[i] = p;
      if (i == 6 && sp == SPACING_120) pat[0] = p;
      if (i > 1 && sp == SPACING_120) `CHK("phases moved", 2, df)
      for (int j = 1; j < i && i < 6; j++)
        `CHK("distinct", 1'b1, p != pat[j])
    end
    for (int k = 0; k < 2; k++)
    begin
      put(1'b1, k ? bad1 : bad0);
      `CHK("invalid valid", 1'b0, valid)
      `CHK("phases off", 6'h00, {pu, pv, pw})
      `CHK("no count", base + 6, hall)
    end
  endtask

  // six electrical cycles forward give three turns at two pole pairs
  task t_turns(input logic signed [7:0] p, input int exp);
    logic signed [COUNT_W-1:0] base;
    do_reset(SPACING_120, p);
    base = hall;
    for (int i = 1; i <= 36; i++)
    begin
      put(1'b0, 3'(i % 6));
      `CHK("pattern", pat[i % 6], {pu, pv, pw})
    end
    `CHK("hall 36", base + 36 * exp, hall)
    `CHK("turns", 32'(3 * exp), turns)
    // last full window held two or three cycles, truncated over two pairs
    `CHK("speed run", 24'(exp), speed)
    repeat (250) @(posedge clk);
    `CHK("speed idle", 24'h0, speed)
  endtask

  // each map value 0 to 5 must give its own pairing of sensors a and b
  task t_maps;
    logic [11:0] seen [6];
    do_reset(SPACING_120, 8'sh01);
    for (int m = 0; m < 6; m++)
    begin
      map <= 3'(m);
      put(1'b1, 3'h1);
      seen[m][5:0] = {pu, pv, pw};
      put(1'b1, 3'h2);
      seen[m][11:6] = {pu, pv, pw};
      for (int j = 0; j < m; j++)
        `CHK("map distinct", 1'b1, seen[m] != seen[j])
    end
  endtask

  // order map 5 reverses the bits before decode
  task t_map;
    logic [2:0] st;
    do_reset(SPACING_120, 8'sh01);
    map <= 3'h5;
    for (int i = 0; i < 6; i++)
    begin
      put(1'b0, 3'(i));
      st = {sc, sb, sa};
      put(1'b1, {st[0], st[1], st[2]});
      `CHK("mapped", pat[i], {pu, pv, pw})
      raw_en <= 1'b0;
    end
  endtask

  task finish_test;
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    n_errors = 0;
    checks = 0;
    nrst = 1'b0;
    spacing = 1'b0;
    raw_en = 1'b0;
    map = 3'h0;
    sector = 3'h0;
    raw = 3'h0;
    poles = 8'sh01;
    for (int i = 0; i < 6; i++) pat[i] = 6'h00;
    t_sweep(SPACING_60, 3'h2, 3'h5);
    t_sweep(SPACING_120, 3'h0, 3'h7);
    t_turns(8'sh02, 1);
    t_turns(-8'sh02, -1);
    t_map;
    t_maps;
    finish_test;
  end
endmodule
